// *** core/kid_pkg.sv ***
// shared constants, types and carriers of the key id download block
package kid_pkg;

  // clock and timing base
  localparam int unsigned KID_CLK_HZ      = 20_000_000;
  localparam int unsigned KID_CYC_PER_MS  = KID_CLK_HZ / 1000;
  localparam int unsigned KID_SYNC_MS     = 100;  // start pulse length
  localparam int unsigned KID_STROBE_MS   = 100;  // strobe period
  localparam int unsigned KID_TAIL_MS     = 100;  // echo wind-down
  localparam int unsigned KID_END_MS      = 200;  // end-of-id hold
  localparam int unsigned KID_FILT_MS     = 20;   // control input filter
  localparam int unsigned KID_FLASH_MS    = 200;  // backlight flash
  localparam int unsigned KID_SYNC_CYC    = KID_SYNC_MS * KID_CYC_PER_MS;
  localparam int unsigned KID_HALF_CYC    = KID_STROBE_MS * KID_CYC_PER_MS
                                            / 2;
  localparam int unsigned KID_TAIL_CYC    = KID_TAIL_MS * KID_CYC_PER_MS;
  localparam int unsigned KID_END_CYC     = KID_END_MS * KID_CYC_PER_MS;
  localparam int unsigned KID_FILT_CYC    = KID_FILT_MS * KID_CYC_PER_MS;
  localparam int unsigned KID_FLASH_CYC   = KID_FLASH_MS * KID_CYC_PER_MS;
  localparam int unsigned KID_TMR_W       = 23;
  localparam int unsigned KID_STRAP_WAIT  = 3;   // edges before strap take

  // identifier layout
  localparam int unsigned KID_ID_W        = 28;
  localparam logic [4:0]  KID_HI_MSB      = 5'h1b;  // bit 27
  localparam logic [4:0]  KID_LO_MSB      = 5'h0d;  // bit 13
  localparam logic [4:0]  KID_PAIR_LAST   = 5'h0d;  // 14 pairs
  localparam logic [4:0]  KID_BIT_LAST    = 5'h1b;  // 28 single bits

  // register map (byte addresses)
  localparam logic [11:0] KID_CTRL_ADDR   = 12'h000;
  localparam logic [11:0] KID_KEYID_ADDR  = 12'h004;
  localparam logic [11:0] KID_MREQ_ADDR   = 12'h008;
  localparam logic [11:0] KID_STAT_ADDR   = 12'h00c;
  localparam int unsigned KID_CTRL_KEY    = 0;   // key present and valid
  localparam int unsigned KID_CTRL_LOCK   = 1;   // lock function configured
  localparam int unsigned KID_CTRL_PSEL   = 2;   // preselection configured
  localparam logic [2:0]  KID_CTRL_RST    = 3'h0;
  localparam logic [2:0]  KID_MODE_MAX    = 3'h4;  // five modes, 0..4
  localparam logic [2:0]  KID_MODE_RST    = 3'h0;

  // status information codes
  localparam logic [3:0]  KID_STAT_NOAUTH = 4'hf;
  localparam logic [3:0]  KID_STAT_SWITCH = 4'he;

  typedef enum logic [1:0] {
    KID_COMM_TX,       // transmitter paced
    KID_COMM_HS,       // request / acknowledge
    KID_COMM_ADV,      // handshake plus lock and confirm
    KID_COMM_ADV2      // second strap code for advanced
  } kid_comm_t;

  typedef enum logic [2:0] {
    KID_TX_IDLE, KID_TX_SYNC, KID_TX_HIGH, KID_TX_LOW, KID_TX_TAIL
  } kid_tx_t;

  typedef enum logic [1:0] {
    KID_HS_IDLE, KID_HS_ACK, KID_HS_END
  } kid_hs_t;

  // pins driven towards the controller
  typedef struct packed {
    logic key_valid_sync;
    logic bit_strobe;
    logic id_tx_hi;
    logic id_tx_lo;
    logic bit_ack;
    logic id_serial_data;
  } kid_link_t;

  // registered apb answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } kid_apb_t;

endpackage : kid_pkg

// *** core/kid_in_filter.sv ***
// input synchroniser with a stable-time filter
`timescale 1ns/1ps
module kid_in_filter
  import kid_pkg::*;
#(
  parameter int unsigned W          = 1,
  parameter int unsigned STABLE_CYC = 1,
  parameter logic        INIT       = 1'b0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0]         sy1;
    logic [W-1:0]         sy2;
    logic [W-1:0]         lvl;
    logic [KID_TMR_W-1:0] cnt;
  } kid_filt_st_t;

  kid_filt_st_t st;
  kid_filt_st_t next_st;

  // two flops, then a new level is adopted once it held STABLE_CYC cycles
  always_comb begin
    next_st     = st;
    next_st.sy1 = pin_in;
    next_st.sy2 = st.sy1;
    if (st.sy2 == st.lvl) begin
      next_st.cnt = '0;
    end else if (st.cnt >= KID_TMR_W'(STABLE_CYC - 1)) begin
      next_st.lvl = st.sy2;
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{sy1: {W{INIT}}, sy2: {W{INIT}}, lvl: {W{INIT}}, cnt: '0};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;

endmodule : kid_in_filter

// *** core/kid_key_download.sv ***
// key id download, mode lock and preselection with apb registers
//
// Notes on behaviour
// - transmitter mode: sync low without key, 100 ms high pulse at start.
// - strobe is a 100 ms square wave, rising edge marks valid bit pair.
// - high line sends bits 27..14, low line bits 13..0, one per period.
// - at each strobe fall the echo is sampled and compared.
// - echo mismatch aborts, pulses sync again and restarts until correct.
// - handshake mode: sync follows key validity; no requests while low.
// - ack high only while the serial data bit may be evaluated.
// - serial line sends 28 bits, msb first, bit 27 down to 0.
// - request rise presents bit and raises ack; request fall drops ack.
// - answers within 10 ms; data held; may start right after sync.
// - after last request fall ack stays high 200 ms as end mark.
// - all 28 bits requested before a fresh download starts.
// - lock input adopted after 20 ms stable; low locks, ends preselect.
// - confirm input adopted after 20 ms; low holds mode outputs.
// - change while locked: flash backlight, no-auth status, no switch.
// - lock inactive while first controller input is held at one.
// - communication mode strap sampled once after power-on only; here it is taken again after every presetn release.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module kid_key_download
  import kid_pkg::*;
#(
  parameter int unsigned SYNC_CYC  = KID_SYNC_CYC,
  parameter int unsigned HALF_CYC  = KID_HALF_CYC,
  parameter int unsigned TAIL_CYC  = KID_TAIL_CYC,
  parameter int unsigned END_CYC   = KID_END_CYC,
  parameter int unsigned FILT_CYC  = KID_FILT_CYC,
  parameter int unsigned FLASH_CYC = KID_FLASH_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // strap and controller inputs
  input  wire logic [1:0]  comm_mode_strap,
  input  wire logic        echo_hi,
  input  wire logic        echo_lo,
  input  wire logic        bit_request,
  input  wire logic        host_input_0,
  input  wire logic        host_input_1,
  // outputs towards the controller
  output logic             key_valid_sync,
  output logic             bit_strobe,
  output logic             id_tx_hi,
  output logic             id_tx_lo,
  output logic             bit_ack,
  output logic             id_serial_data,
  // mode side
  output logic [4:0]       mode_outputs,
  output logic [3:0]       status_info_outputs,
  output logic             backlight_flash
);

  typedef struct packed {
    kid_comm_t               comm;
    logic [1:0]              strap_wait;
    logic                    strap_taken;
    logic [2:0]              ctrl;
    logic [KID_ID_W-1:0]     key_id;
    kid_tx_t                 tx;
    kid_hs_t                 hs;
    logic [KID_TMR_W-1:0]    tmr;
    logic [4:0]              idx;
    logic                    req_prev;
    logic                    done;
    logic [7:0]              retries;
    kid_link_t               link;
    logic [2:0]              cur_mode;
    logic [2:0]              pre_mode;
    logic                    pending;
    logic [KID_TMR_W-1:0]    flash_tmr;
    logic                    flash;
    logic [3:0]              status;
    logic [4:0]              mode_out;
    kid_apb_t                apb;
  } kid_state_t;

  kid_state_t s;
  kid_state_t next_s;

  logic [1:0] strap_sync;
  logic [1:0] echo_sync;
  logic       req_sync;
  logic       lock_level;
  logic       confirm_level;

  // plain two-flop synchronisers for strap, echo and request pins
  kid_in_filter #(.W(2), .STABLE_CYC(1), .INIT(1'b0)) u_strap (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (comm_mode_strap),
    .level   (strap_sync)
  );

  kid_in_filter #(.W(2), .STABLE_CYC(1), .INIT(1'b0)) u_echo (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({echo_hi, echo_lo}),
    .level   (echo_sync)
  );

  kid_in_filter #(.W(1), .STABLE_CYC(1), .INIT(1'b0)) u_req (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (bit_request),
    .level   (req_sync)
  );

  // lock and confirm levels adopted only after 20 ms of stability
  kid_in_filter #(.W(1), .STABLE_CYC(FILT_CYC), .INIT(1'b1)) u_lock (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (host_input_0),
    .level   (lock_level)
  );

  kid_in_filter #(.W(1), .STABLE_CYC(FILT_CYC), .INIT(1'b0)) u_conf (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (host_input_1),
    .level   (confirm_level)
  );

  logic       adv;
  logic       lock_on;
  logic       key_ok;
  logic       wr_en;
  logic       rd_en;
  logic [4:0] nidx;

  always_comb begin
    adv     = (s.comm == KID_COMM_ADV) || (s.comm == KID_COMM_ADV2);
    // a high level on the lock input deactivates the lock
    lock_on = adv && s.ctrl[KID_CTRL_LOCK] && !lock_level;
    key_ok  = s.ctrl[KID_CTRL_KEY] && s.strap_taken;
    wr_en   = psel && penable && pwrite && s.apb.pready;
    rd_en   = psel && penable && !s.apb.pready;
    nidx    = s.idx + 5'h01;
  end

  // next state
  always_comb begin
    next_s = s;

    // strap caught once, a few edges after reset release
    if (!s.strap_taken) begin
      if (s.strap_wait == 2'(KID_STRAP_WAIT)) begin
        next_s.comm        = kid_comm_t'(strap_sync);
        next_s.strap_taken = 1'b1;
      end else begin
        next_s.strap_wait = s.strap_wait + 2'h1;
      end
    end

    // apb: one wait state, answer registered
    next_s.apb.pready  = rd_en;
    next_s.apb.pslverr = 1'b0;
    next_s.apb.prdata  = '0;
    if (rd_en) begin
      case (paddr)
        KID_CTRL_ADDR:  next_s.apb.prdata = {29'h0, s.ctrl};
        KID_KEYID_ADDR: next_s.apb.prdata = {4'h0, s.key_id};
        KID_MREQ_ADDR:  next_s.apb.prdata = {29'h0, s.pre_mode};
        KID_STAT_ADDR:  next_s.apb.prdata = {11'h0, s.idx, s.retries,
                                             s.done, lock_on, s.pending,
                                             s.cur_mode, s.comm};
        default:        next_s.apb.pslverr = !pwrite;  // writes ignored
      endcase
    end
    if (wr_en) begin
      case (paddr)
        KID_CTRL_ADDR:  next_s.ctrl   = pwdata[2:0];
        KID_KEYID_ADDR: next_s.key_id = pwdata[KID_ID_W-1:0];
        default:        ;
      endcase
    end

    // handshake request edge tracking
    next_s.req_prev = req_sync;
    if (!s.ctrl[KID_CTRL_KEY]) begin
      next_s.done = 1'b0;
    end

    if (s.comm == KID_COMM_TX) begin
      // transmitter paced download
      next_s.tmr = s.tmr + 1'b1;
      case (s.tx)
        KID_TX_IDLE: begin
          next_s.link = '0;
          next_s.tmr  = '0;
          if (key_ok && !s.done) begin
            next_s.link.key_valid_sync = 1'b1;
            next_s.tx                  = KID_TX_SYNC;
          end
        end
        KID_TX_SYNC: begin
          if (s.tmr == KID_TMR_W'(SYNC_CYC - 1)) begin
            next_s.tmr                 = '0;
            next_s.idx                 = '0;
            next_s.link.key_valid_sync = 1'b0;
            next_s.link.bit_strobe     = 1'b1;
            next_s.link.id_tx_hi       = s.key_id[KID_HI_MSB];
            next_s.link.id_tx_lo       = s.key_id[KID_LO_MSB];
            next_s.tx                  = KID_TX_HIGH;
          end
        end
        KID_TX_HIGH: begin
          if (s.tmr == KID_TMR_W'(HALF_CYC - 1)) begin
            next_s.tmr             = '0;
            next_s.link.bit_strobe = 1'b0;
            // the echo must be settled by the strobe fall
            if (echo_sync != {s.link.id_tx_hi, s.link.id_tx_lo}) begin
              next_s.retries             = s.retries + 8'h01;
              next_s.link                = '0;
              next_s.link.key_valid_sync = 1'b1;
              next_s.tx                  = KID_TX_SYNC;
            end else begin
              next_s.tx = KID_TX_LOW;
            end
          end
        end
        KID_TX_LOW: begin
          if (s.tmr == KID_TMR_W'(HALF_CYC - 1)) begin
            next_s.tmr = '0;
            if (s.idx == KID_PAIR_LAST) begin
              next_s.link.id_tx_hi = 1'b0;
              next_s.link.id_tx_lo = 1'b0;
              next_s.tx            = KID_TX_TAIL;
            end else begin
              next_s.idx             = nidx;
              next_s.link.bit_strobe = 1'b1;
              next_s.link.id_tx_hi   = s.key_id[KID_HI_MSB - nidx];
              next_s.link.id_tx_lo   = s.key_id[KID_LO_MSB - nidx];
              next_s.tx              = KID_TX_HIGH;
            end
          end
        end
        KID_TX_TAIL: begin
          // leave the controller time to wind its echo down
          if (s.tmr == KID_TMR_W'(TAIL_CYC - 1)) begin
            next_s.done = 1'b1;
            next_s.tx   = KID_TX_IDLE;
          end
        end
        default: next_s.tx = KID_TX_IDLE;
      endcase
      if (!key_ok) begin
        next_s.link = '0;
        next_s.tx   = KID_TX_IDLE;
      end
    end else begin
      // handshake download, also used in advanced mode
      next_s.link.key_valid_sync = key_ok;
      next_s.link.bit_strobe     = 1'b0;
      next_s.link.id_tx_hi       = 1'b0;
      next_s.link.id_tx_lo       = 1'b0;
      case (s.hs)
        KID_HS_IDLE: begin
          next_s.link.bit_ack = 1'b0;
          if (key_ok && req_sync && !s.req_prev) begin
            // answer one cycle after the synchronised edge
            next_s.link.id_serial_data =
              s.key_id[KID_BIT_LAST - s.idx];
            next_s.link.bit_ack        = 1'b1;
            next_s.hs                  = KID_HS_ACK;
          end
        end
        KID_HS_ACK: begin
          if (!req_sync) begin
            if (s.idx == KID_BIT_LAST) begin
              next_s.tmr = '0;
              next_s.hs  = KID_HS_END;
            end else begin
              next_s.idx          = nidx;
              next_s.link.bit_ack = 1'b0;
              next_s.hs           = KID_HS_IDLE;
            end
          end
        end
        KID_HS_END: begin
          next_s.tmr = s.tmr + 1'b1;
          if (s.tmr == KID_TMR_W'(END_CYC - 1)) begin
            next_s.link.bit_ack        = 1'b0;
            next_s.link.id_serial_data = 1'b0;
            next_s.idx                 = '0;
            next_s.done                = 1'b1;
            next_s.hs                  = KID_HS_IDLE;
          end
        end
        default: next_s.hs = KID_HS_IDLE;
      endcase
      if (!key_ok) begin
        next_s.link = '0;
        next_s.idx  = '0;
        next_s.hs   = KID_HS_IDLE;
      end
    end

    // mode selection: lock, preselection and confirm
    if (s.flash_tmr != '0) begin
      next_s.flash_tmr = s.flash_tmr - 1'b1;
    end else begin
      next_s.flash  = 1'b0;
      next_s.status = {1'b0, s.cur_mode};
    end
    if (adv && s.ctrl[KID_CTRL_LOCK] && !lock_level) begin
      next_s.pending = 1'b0;
    end
    if (wr_en && (paddr == KID_MREQ_ADDR) &&
        (pwdata[2:0] <= KID_MODE_MAX)) begin
      if (lock_on) begin
        next_s.flash     = 1'b1;
        next_s.status    = KID_STAT_NOAUTH;
        next_s.flash_tmr = KID_TMR_W'(FLASH_CYC - 1);
      end else if (adv && s.ctrl[KID_CTRL_PSEL]) begin
        next_s.pre_mode = pwdata[2:0];                   // last one wins
        next_s.pending  = 1'b1;
      end else begin
        next_s.cur_mode = pwdata[2:0];
      end
    end else if (s.pending && confirm_level && !lock_on) begin
      next_s.cur_mode  = s.pre_mode;
      next_s.pending   = 1'b0;
      next_s.status    = KID_STAT_SWITCH;
      next_s.flash_tmr = KID_TMR_W'(FLASH_CYC - 1);
    end
    next_s.mode_out = 5'h01 << next_s.cur_mode;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.cur_mode <= KID_MODE_RST;
      s.ctrl     <= KID_CTRL_RST;
      s.mode_out <= 5'h01;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign prdata              = s.apb.prdata;
  assign pready              = s.apb.pready;
  assign pslverr             = s.apb.pslverr;
  assign key_valid_sync      = s.link.key_valid_sync;
  assign bit_strobe          = s.link.bit_strobe;
  assign id_tx_hi            = s.link.id_tx_hi;
  assign id_tx_lo            = s.link.id_tx_lo;
  assign bit_ack             = s.link.bit_ack;
  assign id_serial_data      = s.link.id_serial_data;
  assign mode_outputs        = s.mode_out;
  assign status_info_outputs = s.status;
  assign backlight_flash     = s.flash;

endmodule : kid_key_download

// *** test/kid_dl_checker.sv ***
// assertions on the pins of the key id download block
`timescale 1ns/1ps
module kid_dl_checker
  import kid_pkg::*;
#(
  parameter int unsigned SYNC_CYC = 20,
  parameter int unsigned HALF_CYC = 10,
  parameter int unsigned END_CYC  = 40
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [1:0] comm_mode_strap,
  input wire logic       bit_request,
  input wire logic       key_valid_sync,
  input wire logic       bit_strobe,
  input wire logic       bit_ack,
  input wire logic       id_serial_data,
  input wire logic [3:0] status_info_outputs,
  input wire logic       backlight_flash
);
  int unsigned n_hi;
  int unsigned n_sy;
  int unsigned n_end;
  logic        tx;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign tx = (comm_mode_strap == 2'h0);
  // run lengths of strobe high, sync high, ack with request low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_hi  <= 0;
      n_sy  <= 0;
      n_end <= 0;
    end else begin
      n_hi  <= bit_strobe ? n_hi + 1 : 0;
      n_sy  <= key_valid_sync ? n_sy + 1 : 0;
      n_end <= (bit_ack && !bit_request) ? n_end + 1 : 0;
    end
  end
  property p_sync_len;
    tx && $fell(key_valid_sync) |-> n_sy == SYNC_CYC && $rose(bit_strobe);
  endproperty
  a_sync_len: assert property (p_sync_len)
    else $error("sync pulse length wrong");
  property p_hi_len;
    $fell(bit_strobe) |-> n_hi == HALF_CYC ##1 !bit_strobe [*8];
  endproperty
  a_hi_len: assert property (p_hi_len)
    else $error("strobe half period wrong");
  property p_ack_resp;
    $rose(bit_request) && !bit_ack |-> ##[1:8] (bit_ack || !key_valid_sync);
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("no ack after request");
  property p_ack_cause;
    $rose(bit_ack) |-> bit_request && key_valid_sync;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ack_data;
    bit_ack && $past(bit_ack) |-> $stable(id_serial_data);
  endproperty
  a_ack_data: assert property (p_ack_data)
    else $error("serial data moved under ack");
  property p_ack_end;
    $fell(bit_ack) && key_valid_sync |->
      n_end inside {[0:8], [END_CYC:END_CYC + 8]};
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("ack release time wrong");
  property p_abort;
    !tx && $fell(key_valid_sync) |-> ##[0:2] !(bit_ack || id_serial_data);
  endproperty
  a_abort: assert property (p_abort)
    else $error("lines not cleared on key loss");
  property p_noauth;
    $rose(backlight_flash) |-> ##[0:1] status_info_outputs == KID_STAT_NOAUTH;
  endproperty
  a_noauth: assert property (p_noauth)
    else $error("no-auth status missing");
endmodule : kid_dl_checker

bind kid_key_download kid_dl_checker #(.SYNC_CYC(SYNC_CYC),
  .HALF_CYC(HALF_CYC), .END_CYC(END_CYC)) u_kid_chk (.pclk, .presetn,
  .comm_mode_strap, .bit_request, .key_valid_sync, .bit_strobe, .bit_ack,
  .id_serial_data, .status_info_outputs, .backlight_flash);

// *** test/kid_ctrl_model.sv ***
// controller model: echoes sent pairs, requests handshake bits
`timescale 1ns/1ps
module kid_ctrl_model (
  input  wire logic        pclk,
  input  wire logic        hs_go,
  input  wire logic        corrupt,
  input  wire logic        key_valid_sync,
  input  wire logic        bit_strobe,
  input  wire logic        id_tx_hi,
  input  wire logic        id_tx_lo,
  input  wire logic        bit_ack,
  input  wire logic        id_serial_data,
  output logic             echo_hi,
  output logic             echo_lo,
  output logic             bit_request,
  output logic      [27:0] rx_id,
  output logic      [5:0]  rx_cnt,
  output logic      [27:0] tx_id
);
  logic       strobe_d;
  logic       flipped;
  logic [4:0] low_cnt;
  logic [1:0] tick;
  initial begin
    {echo_hi, echo_lo, bit_request, strobe_d, flipped} = 5'h00;
    {rx_id, tx_id, rx_cnt, low_cnt, tick} = 69'h0;
  end
  // echo at strobe rise, release in tail; paced requests, 200 ns phases
  always @(posedge pclk) begin
    strobe_d <= bit_strobe;
    low_cnt  <= bit_strobe ? 5'h00 : low_cnt + {4'h0, low_cnt != 5'h1f};
    tick     <= tick + 2'h1;
    if (bit_strobe && !strobe_d) begin
      echo_hi <= id_tx_hi ^ (corrupt && !flipped);
      echo_lo <= id_tx_lo;
      flipped <= corrupt;
      tx_id   <= {tx_id[26:14], id_tx_hi, tx_id[12:0], id_tx_lo};
    end else if (low_cnt == 5'h0f) begin
      echo_hi <= 1'b0;
      echo_lo <= 1'b0;
    end
    if (!hs_go || !key_valid_sync) begin
      bit_request <= 1'b0;
      if (!hs_go)
        rx_cnt <= 6'h00;
    end else if (tick == 2'h3) begin
      if (!bit_request && !bit_ack && rx_cnt != 6'h1c)
        bit_request <= 1'b1;
      else if (bit_request && bit_ack) begin
        rx_id       <= {rx_id[26:0], id_serial_data};
        rx_cnt      <= rx_cnt + 6'h01;
        bit_request <= 1'b0;
      end
    end
  end
endmodule : kid_ctrl_model

// *** test/kid_key_download_test.sv ***
// self-checking bench of the key id download block
`timescale 1ns/1ps
`define KID_CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) \
  begin n_errors++; $display("BAD %s exp %h got %h", nm, exp, got); end end
`define KID_WAIT(c) while (!(c)) @(posedge pclk);
module kid_key_download_test;
  import kid_pkg::*;
  localparam int unsigned FILT = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0]  comm_mode_strap;
  logic        echo_hi, echo_lo, bit_request, host_input_0, host_input_1;
  logic        key_valid_sync, bit_strobe, id_tx_hi, id_tx_lo, bit_ack;
  logic        id_serial_data, backlight_flash, hs_go, corrupt, rerr;
  logic [4:0]  mode_outputs;
  logic [3:0]  status_info_outputs;
  logic [27:0] rx_id, tx_id, key;
  logic [5:0]  rx_cnt;
  int          n_errors, num_checks, k;

  kid_key_download #(.SYNC_CYC(20), .HALF_CYC(10), .TAIL_CYC(20),
    .END_CYC(40), .FILT_CYC(FILT), .FLASH_CYC(16)) uut (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .comm_mode_strap, .echo_hi, .echo_lo, .bit_request, .host_input_0,
    .host_input_1, .key_valid_sync, .bit_strobe, .id_tx_hi, .id_tx_lo,
    .bit_ack, .id_serial_data, .mode_outputs, .status_info_outputs,
    .backlight_flash);
  kid_ctrl_model u_ctrl (.pclk, .hs_go, .corrupt, .key_valid_sync,
    .bit_strobe, .id_tx_hi, .id_tx_lo, .bit_ack, .id_serial_data, .echo_hi,
    .echo_lo, .bit_request, .rx_id, .rx_cnt, .tx_id);

  // bench clock, 50 ns period
  always #25 pclk = ~pclk;

  function automatic logic [4:0] onehot(input logic [2:0] m);
    return 5'h01 << m;
  endfunction : onehot

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic [1:0] m);
    presetn         <= 1'b0;
    comm_mode_strap <= m;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : do_reset

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // cut a hang short
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    $display("BAD watchdog exp finish got hang");
    print_verdict();
  end

  // main sequence: transmitter, handshake, advanced
  initial begin
    {pclk, presetn, psel, penable, pwrite, hs_go, corrupt} = 7'h00;
    {paddr, pwdata, comm_mode_strap, host_input_1} = 47'h0;
    host_input_0 = 1'b1;
    {n_errors, num_checks} = 64'h0;
    k = $urandom(32'h7f32);
    do_reset(2'h0);
    apb(1'b0, 12'h010, 32'h0);
    `KID_CHK("unmapped", 1'b1, rerr)
    key = 28'($urandom);
    corrupt <= 1'b1;
    apb(1'b1, KID_KEYID_ADDR, {4'h0, key});
    apb(1'b1, KID_CTRL_ADDR, 32'h1);
    rdat = 32'h0;
    while (rdat[7] !== 1'b1)
      apb(1'b0, KID_STAT_ADDR, 32'h0);
    `KID_CHK("retries", 8'h01, rdat[15:8])
    `KID_CHK("tx_id", key, tx_id)
    corrupt <= 1'b0;
    apb(1'b1, KID_CTRL_ADDR, 32'h0);
    @(posedge pclk);
    `KID_CHK("sync_idle", 1'b0, key_valid_sync)
    do_reset(2'h1);
    key = 28'($urandom);
    apb(1'b1, KID_KEYID_ADDR, {4'h0, key});
    apb(1'b1, KID_CTRL_ADDR, 32'h1);
    `KID_WAIT(key_valid_sync === 1'b1)
    `KID_CHK("sync_hs", 1'b1, key_valid_sync)
    hs_go <= 1'b1;
    `KID_WAIT(rx_cnt == 6'h1c)
    `KID_CHK("hs_id", key, rx_id)
    `KID_WAIT(bit_ack === 1'b0)
    hs_go <= 1'b0;
    @(posedge pclk);
    hs_go <= 1'b1;
    `KID_WAIT(rx_cnt == 6'h05)
    `KID_CHK("restart", key[27:23], rx_id[4:0])
    apb(1'b1, KID_CTRL_ADDR, 32'h0);
    repeat (4) @(posedge pclk);
    `KID_CHK("abort", 3'h0, {key_valid_sync, bit_ack, id_serial_data})
    hs_go <= 1'b0;
    do_reset({1'b1, 1'($urandom)});
    apb(1'b1, KID_CTRL_ADDR, 32'h2);
    host_input_0 <= 1'b0;
    repeat (FILT - 4) @(posedge pclk);
    host_input_0 <= 1'b1;
    apb(1'b1, KID_MREQ_ADDR, 32'h2);
    repeat (4) @(posedge pclk);
    `KID_CHK("glitch", onehot(3'h2), mode_outputs)
    host_input_0 <= 1'b0;
    repeat (FILT + 8) @(posedge pclk);
    apb(1'b1, KID_MREQ_ADDR, 32'h3);
    `KID_WAIT(backlight_flash === 1'b1)
    @(posedge pclk);
    `KID_CHK("locked", onehot(3'h2), mode_outputs)
    `KID_CHK("noauth", KID_STAT_NOAUTH, status_info_outputs)
    host_input_0 <= 1'b1;
    repeat (FILT + 24) @(posedge pclk);
    apb(1'b1, KID_CTRL_ADDR, 32'h6);
    apb(1'b1, KID_MREQ_ADDR, 32'h1);
    repeat (4) @(posedge pclk);
    `KID_CHK("held", onehot(3'h2), mode_outputs)
    host_input_1 <= 1'b1;
    `KID_WAIT(mode_outputs === onehot(3'h1))
    `KID_CHK("confirmed", onehot(3'h1), mode_outputs)
    `KID_CHK("switched", KID_STAT_SWITCH, status_info_outputs)
    host_input_1 <= 1'b0;
    repeat (FILT + 24) @(posedge pclk);
    apb(1'b1, KID_MREQ_ADDR, 32'h4);
    host_input_0 <= 1'b0;
    repeat (FILT + 8) @(posedge pclk);
    host_input_0 <= 1'b1;
    host_input_1 <= 1'b1;
    repeat (FILT + 8) @(posedge pclk);
    `KID_CHK("dropped", onehot(3'h1), mode_outputs)
    print_verdict();
  end
endmodule : kid_key_download_test
